// ==== src/smp_dev.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - command byte: index, selector, write, parity
// - short memories use three-byte frames
// - long memories use four-byte frames
// - read data returns in the next frame
// - status byte leads every response
// - status low bits always 010
// - any error sets status top bit in last_status; the status byte sent on the link stays 02
// - bad odd parity flags and rejects
// - index and selector both set is illegal
// - unsupported selector flags illegal command
// - only 16, 24 or 32 clocks allowed
// - master checks status on every transfer
// - register file uses 16-clock frames
// - parity makes command byte odd
// - sample falling, drive rising, MSB first
// - writes commit after chip select rises
// - deselect resets port, output released
module smp_dev #(
  parameter logic [7:0] SEL_SUPPORT = 8'hFF
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // serial link
  smp_if.dev link,
  // memory access port
  output logic mem_wr,
  output logic mem_rd,
  output logic [2:0] mem_sel,
  output logic [2:0] mem_reg_idx,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // frame report
  output logic frame_done,
  output logic [7:0] last_status
);

  // pin synchronisers; stage 3 only feeds edge detection
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic mosi_s1_reg, mosi_s2_reg;

  logic [5:0] cnt_reg;
  logic [31:0] sr_reg;
  logic [7:0] cmd_reg;
  logic cmd_valid_reg;
  logic [7:0] rd_data_reg;
  logic rd_pend_reg;
  logic miso_reg;
  logic miso_oe_reg;
  logic mem_wr_reg;
  logic mem_rd_reg;
  logic [2:0] mem_sel_reg;
  logic [2:0] mem_idx_reg;
  logic [15:0] mem_addr_reg;
  logic [7:0] mem_wdata_reg;
  logic frame_done_reg;
  logic [7:0] last_status_reg;

  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  wire cs_fall = ~cs_s2_reg & cs_s3_reg;
  wire cs_rise = cs_s2_reg & ~cs_s3_reg;
  wire selected = ~cs_s2_reg;

  wire [2:0] cmd_idx = cmd_reg[smp_pkg::CMD_IDX_LSB +: 3];
  wire [2:0] cmd_sel = cmd_reg[smp_pkg::CMD_SEL_LSB +: 3];
  wire cmd_wr = cmd_reg[smp_pkg::CMD_WR_BIT];

  // flags only judge what has arrived so far
  wire par_err = cmd_valid_reg & ~(^cmd_reg);
  wire adr_err = cmd_valid_reg & (cmd_idx != 3'h0)
    & (cmd_sel != smp_pkg::SEL_REG);
  wire cmd_err = cmd_valid_reg & ~SEL_SUPPORT[cmd_sel];
  wire [5:0] need_len = smp_pkg::smp_frame_len(cmd_sel);
  wire len_legal = (cnt_reg == smp_pkg::LEN_REG)
    | (cnt_reg == smp_pkg::LEN_SHORT)
    | (cnt_reg == smp_pkg::LEN_LONG);
  // a legal count that disagrees with the command still sets cnt_err
  wire cnt_err = ~len_legal | ~cmd_valid_reg
    | (cnt_reg != need_len);

  wire any_live = par_err | adr_err | cmd_err;
  wire [7:0] live_status = {any_live, par_err, adr_err, cmd_err, 1'b0,
    smp_pkg::ST_FIXED};
  wire any_end = any_live | cnt_err;
  wire [7:0] end_status = {any_end, par_err, adr_err, cmd_err, cnt_err,
    smp_pkg::ST_FIXED};

  // response: status first, then a pending read byte, then zeros
  wire [2:0] bit_pos = ~cnt_reg[2:0];
  wire tx_bit = (cnt_reg < 6'h08) ? live_status[bit_pos] :
    (cnt_reg < 6'h10) ? rd_data_reg[bit_pos] : 1'b0;

  wire commit_ok = cs_rise & ~any_end;
  wire [15:0] frame_addr = (need_len == smp_pkg::LEN_LONG) ? sr_reg[23:8] :
    (need_len == smp_pkg::LEN_SHORT) ? {8'h00, sr_reg[15:8]} : 16'h0000;

  // synchronisers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end else if (clk_en) begin
      sclk_s1_reg <= link.sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg <= link.cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      mosi_s1_reg <= link.mosi;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  // receive shifter, clock counter and command capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 6'h00;
      sr_reg <= 32'h0000_0000;
      cmd_reg <= 8'h00;
      cmd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall | ~selected) begin
        cnt_reg <= 6'h00;
        cmd_valid_reg <= 1'b0;
      end else if (sclk_fall) begin
        sr_reg <= {sr_reg[30:0], mosi_s2_reg};
        if (cnt_reg != 6'h3F) begin
          cnt_reg <= cnt_reg + 6'h01;
        end
        if (cnt_reg == 6'h07) begin
          cmd_reg <= {sr_reg[6:0], mosi_s2_reg};
          cmd_valid_reg <= 1'b1;
        end
      end
    end
  end

  // serial output: drive on rising edges, released while deselected
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else if (clk_en) begin
      miso_oe_reg <= selected;
      if (~selected) begin
        miso_reg <= 1'b0;
      end else if (sclk_rise) begin
        miso_reg <= tx_bit;
      end
    end
  end

  // commit on the system clock once the frame is closed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_wr_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_sel_reg <= 3'h0;
      mem_idx_reg <= 3'h0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      frame_done_reg <= 1'b0;
      last_status_reg <= smp_pkg::ST_OK;
    end else if (clk_en) begin
      mem_wr_reg <= commit_ok & cmd_wr;
      mem_rd_reg <= commit_ok & ~cmd_wr;
      frame_done_reg <= cs_rise;
      if (cs_rise) begin
        last_status_reg <= end_status;
      end
      if (commit_ok) begin
        mem_sel_reg <= cmd_sel;
        mem_idx_reg <= cmd_idx;
        mem_addr_reg <= frame_addr;
        mem_wdata_reg <= sr_reg[7:0];
      end
    end
  end

  // read result is held for the next frame only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
    end else if (clk_en) begin
      rd_pend_reg <= mem_rd_reg;
      if (rd_pend_reg) begin
        rd_data_reg <= mem_rdata;
      end else if (cs_rise) begin
        rd_data_reg <= 8'h00;
      end
    end
  end

  assign link.miso = miso_reg;
  assign link.miso_oe = miso_oe_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_rd = mem_rd_reg;
  assign mem_sel = mem_sel_reg;
  assign mem_reg_idx = mem_idx_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign frame_done = frame_done_reg;
  assign last_status = last_status_reg;

endmodule
`default_nettype wire

// ==== src/smp_pkg.sv ====
`default_nettype none
package smp_pkg;

  // memory selector codes, command bits 4:2
  localparam logic [2:0] SEL_REG = 3'h0;
  localparam logic [2:0] SEL_OTP = 3'h1;
  localparam logic [2:0] SEL_XRAM = 3'h2;
  localparam logic [2:0] SEL_EEC = 3'h3;
  localparam logic [2:0] SEL_IDATA = 3'h4;
  localparam logic [2:0] SEL_TEST = 3'h5;
  localparam logic [2:0] SEL_EXT_SFR = 3'h6;
  localparam logic [2:0] SEL_DEVEL = 3'h7;

  // command byte layout
  localparam int CMD_IDX_LSB = 5;
  localparam int CMD_SEL_LSB = 2;
  localparam int CMD_WR_BIT = 1;
  localparam int CMD_PAR_BIT = 0;

  // status byte layout
  localparam int ST_FAIL = 7;
  localparam int ST_PAR = 6;
  localparam int ST_ADR = 5;
  localparam int ST_CMD = 4;
  localparam int ST_CNT = 3;
  localparam logic [2:0] ST_FIXED = 3'h2;
  localparam logic [7:0] ST_OK = 8'h02;

  // frame lengths in serial clocks
  localparam logic [5:0] LEN_REG = 6'h10;
  localparam logic [5:0] LEN_SHORT = 6'h18;
  localparam logic [5:0] LEN_LONG = 6'h20;
  localparam logic [5:0] LEN_MAX = 6'h20;

  // timing
  localparam int CLK_NS = 20;
  localparam int SCLK_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_NS / (2 * CLK_NS);
  localparam int GAP_NS = 160;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;

  function automatic logic [5:0] smp_frame_len(input logic [2:0] sel);
    case (sel)
      SEL_REG: return LEN_REG;
      SEL_OTP, SEL_XRAM, SEL_DEVEL: return LEN_LONG;
      default: return LEN_SHORT;
    endcase
  endfunction

endpackage
`default_nettype wire

// ==== src/smp_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface smp_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    output miso,
    output miso_oe
  );

  modport mst (
    output sclk,
    output cs_n,
    output mosi,
    input miso,
    input miso_oe
  );
endinterface
`default_nettype wire

// ==== src/smp_mst.sv ====
`timescale 1ns/10ps
`default_nettype none
module smp_mst #(
  parameter int SCLK_HALF = smp_pkg::SCLK_HALF_CYC,
  parameter int GAP = smp_pkg::GAP_CYC
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // serial link
  smp_if.mst link,
  // request
  input wire logic req,
  input wire logic [2:0] req_sel,
  input wire logic [2:0] req_idx,
  input wire logic req_wr,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_data,
  // answer
  output logic busy,
  output logic done,
  output logic [7:0] rsp_status,
  output logic [7:0] rsp_data,
  output logic rsp_fail
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL, ST_GAP
  } smp_mst_state_e;

  localparam logic [7:0] HALF = 8'(SCLK_HALF);
  localparam logic [7:0] LAST_PH = 8'(2 * SCLK_HALF - 1);
  localparam logic [7:0] GAP_LAST = 8'(GAP - 1);

  smp_mst_state_e state_reg;
  logic [7:0] ph_reg;
  logic [5:0] nbit_reg;
  logic [5:0] len_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic sclk_reg, cs_n_reg, mosi_reg;
  logic miso_s1_reg, miso_s2_reg;
  logic busy_reg, done_reg, fail_reg;
  logic [7:0] status_reg, data_reg;

  // command byte with odd parity over the whole byte
  wire [6:0] cmd_hi = {req_idx, req_sel, req_wr};
  wire [7:0] cmd = {cmd_hi, ~(^cmd_hi)};
  wire [5:0] req_len = smp_pkg::smp_frame_len(req_sel);
  wire [31:0] req_word = (req_len == smp_pkg::LEN_LONG) ?
    {cmd, req_addr, req_data} :
    (req_len == smp_pkg::LEN_SHORT) ? {cmd, req_addr[7:0], req_data, 8'h00} :
    {cmd, req_data, 16'h0000};
  // left-align what came back so status sits at the top
  wire [31:0] rx_al = rx_reg << (smp_pkg::LEN_MAX - len_reg);
  wire ph_end = (ph_reg == LAST_PH);
  wire last_bit = (nbit_reg == len_reg - 6'h01);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else if (clk_en) begin
      miso_s1_reg <= link.miso;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      ph_reg <= 8'h00;
      nbit_reg <= 6'h00;
      len_reg <= smp_pkg::LEN_REG;
      tx_reg <= 32'h0000_0000;
      rx_reg <= 32'h0000_0000;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (req) begin
            tx_reg <= req_word;
            len_reg <= req_len;
            nbit_reg <= 6'h00;
            ph_reg <= 8'h00;
            cs_n_reg <= 1'b0;
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          ph_reg <= ph_reg + 8'h01;
          if (ph_reg == HALF - 8'h01) begin
            ph_reg <= 8'h00;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          ph_reg <= ph_reg + 8'h01;
          if (ph_reg == 8'h00) begin
            sclk_reg <= 1'b1;
            mosi_reg <= tx_reg[31];
            tx_reg <= {tx_reg[30:0], 1'b0};
          end
          if (ph_reg == HALF) begin
            sclk_reg <= 1'b0;
          end
          // sample late in the low phase to absorb the slave's sync delay
          if (ph_end) begin
            rx_reg <= {rx_reg[30:0], miso_s2_reg};
            nbit_reg <= nbit_reg + 6'h01;
            ph_reg <= 8'h00;
            if (last_bit) begin
              state_reg <= ST_TRAIL;
            end
          end
        end
        ST_TRAIL: begin
          ph_reg <= ph_reg + 8'h01;
          if (ph_reg == HALF - 8'h01) begin
            cs_n_reg <= 1'b1;
            ph_reg <= 8'h00;
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          ph_reg <= ph_reg + 8'h01;
          if (ph_reg == GAP_LAST) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      status_reg <= 8'h00;
      data_reg <= 8'h00;
      fail_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= (state_reg != ST_IDLE) | req;
      done_reg <= (state_reg == ST_GAP) & (ph_reg == 8'h00);
      if ((state_reg == ST_GAP) & (ph_reg == 8'h00)) begin
        status_reg <= rx_al[31:24];
        data_reg <= rx_al[23:16];
        fail_reg <= rx_al[31];
      end
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = mosi_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign rsp_status = status_reg;
  assign rsp_data = data_reg;
  assign rsp_fail = fail_reg;

endmodule
`default_nettype wire

// ==== testbench/smp_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module smp_sva (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic sclk_reg;
  logic [5:0] rise_reg;
  logic [3:0] fall_reg;
  logic [7:0] cmd_reg;
  wire logic rise_w = sclk & ~sclk_reg;
  wire logic fall_w = ~sclk & sclk_reg & (fall_reg < 4'h8);

  // counts and command byte of the frame in flight
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_reg <= 1'h0;
      rise_reg <= 6'h00;
      fall_reg <= 4'h0;
      cmd_reg <= 8'h00;
    end else begin
      sclk_reg <= sclk;
      rise_reg <= cs_n ? 6'h00 : rise_reg + {5'h00, rise_w};
      fall_reg <= cs_n ? 4'h0 : fall_reg + {3'h0, fall_w};
      if (fall_w) begin
        cmd_reg <= {cmd_reg[6:0], mosi};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  oe_idle_a: assert property (cs_n [*4] |-> !miso_oe)
    else $error("slave drives its output while deselected");
  oe_on_a: assert property ($fell(cs_n) |-> ##[1:5] miso_oe)
    else $error("slave output not enabled after select");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock moves outside a frame");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("deselect gap too short");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  mosi_hold_a: assert property ($fell(sclk) |-> $stable(mosi) [*2])
    else $error("master data moves at the sampling edge");
  clk_count_a: assert property ($rose(cs_n) |->
      (rise_reg == 6'h10 || rise_reg == 6'h18 || rise_reg == 6'h20))
    else $error("frame not 16, 24 or 32 clocks");
  cmd_parity_a: assert property ($rose(cs_n) |-> ^cmd_reg)
    else $error("command byte parity not odd");

  cover property ($rose(cs_n) && rise_reg == 6'h10);
  cover property ($rose(cs_n) && rise_reg == 6'h18);
  cover property ($rose(cs_n) && rise_reg == 6'h20);
  cover property (!cs_n && miso_oe && miso);
endmodule
`default_nettype wire

// ==== testbench/smp_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module smp_tb_top;
  logic clk, sys_rst, req, req_wr, busy, done, rsp_fail;
  logic [2:0] req_sel, req_idx, mem_sel, mem_reg_idx;
  logic [15:0] req_addr, mem_addr;
  logic [7:0] req_data, rsp_status, rsp_data, mem_wdata, mem_rdata;
  logic mem_wr, mem_rd, frame_done, x_wr, x_done;
  logic [7:0] last_status, x_status;
  logic [29:0] wr_log;
  logic [31:0] rx;
  int wr_cnt = 0, x_wr_cnt = 0, fd_cnt = 0, rd_cnt = 0;
  int miscompares, tests_run;
  // refused frames for the second slave: length, bits, status
  int n_tab [4] = '{16, 20, 32, 12};
  logic [31:0] w_tab [4] = '{32'h000022C8, 32'h000137F3, 32'h1F123456,
                             32'h000003F0};
  logic [7:0] e_tab [4] = '{8'hC2, 8'h8A, 8'h92, 8'hFA};

  smp_if link_if ();
  smp_if bad_if ();
  smp_mst smp_mst_i (.clk(clk), .sys_rst(sys_rst), .clk_en(1'h1),
    .link(link_if.mst), .req(req), .req_sel(req_sel), .req_idx(req_idx),
    .req_wr(req_wr), .req_addr(req_addr), .req_data(req_data), .busy(busy),
    .done(done), .rsp_status(rsp_status), .rsp_data(rsp_data),
    .rsp_fail(rsp_fail));
  smp_dev smp_dev_i (.clk(clk), .sys_rst(sys_rst), .clk_en(1'h1),
    .link(link_if.dev), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_sel(mem_sel),
    .mem_reg_idx(mem_reg_idx), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .frame_done(frame_done),
    .last_status(last_status));
  // selector 111 unsupported here, driven by a rule-breaking bench master
  smp_dev #(.SEL_SUPPORT(8'h7F)) smp_dev_x_i (.clk(clk), .sys_rst(sys_rst),
    .clk_en(1'h1), .link(bad_if.dev), .mem_wr(x_wr), .mem_rd(), .mem_sel(),
    .mem_reg_idx(), .mem_addr(), .mem_wdata(), .mem_rdata(8'h00),
    .frame_done(x_done), .last_status(x_status));
  smp_sva smp_sva_i (.clk(clk), .sys_rst(sys_rst), .sclk(link_if.sclk),
    .cs_n(link_if.cs_n), .mosi(link_if.mosi), .miso(link_if.miso),
    .miso_oe(link_if.miso_oe));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // memory stand-in: read data depends on the address only
  always @(posedge clk) begin
    mem_rdata <= mem_addr[7:0] ^ 8'h5A;
    if (mem_wr) begin
      wr_cnt <= wr_cnt + 1;
      wr_log <= {mem_sel, mem_reg_idx, mem_addr, mem_wdata};
    end
    if (x_wr) begin
      x_wr_cnt <= x_wr_cnt + 1;
    end
    if (frame_done) begin
      fd_cnt <= fd_cnt + 1;
    end
    if (mem_rd) begin
      rd_cnt <= rd_cnt + 1;
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // 0: master done, 1: master idle, 2: second slave frame closed
  task automatic wait_for(input int which);
    for (int k = 0; k < 600; k++) begin
      if ((which == 0 && done === 1'h1) || (which == 1 && busy === 1'h0)
          || (which == 2 && x_done === 1'h1)) return;
      @(posedge clk);
      #1;
    end
    // a limit that runs out ends the run as a failure
    miscompares++;
    stop_test();
  endtask

  task automatic xfer(input logic [2:0] s, input logic [2:0] i,
                      input logic w, input logic [15:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    req <= 1'h1;
    req_sel <= s;
    req_idx <= i;
    req_wr <= w;
    req_addr <= a;
    req_data <= d;
    @(posedge clk);
    req <= 1'h0;
    wait_for(0);
    wait_for(1);
    chk(rsp_status, smp_pkg::ST_OK);
    chk(rsp_fail, 1'h0);
  endtask

  // rule-breaking serial master; a released output reads as z
  task automatic send_raw(input int n, input logic [31:0] w);
    rx = 32'h00000000;
    @(posedge clk);
    bad_if.cs_n <= 1'h0;
    repeat (4) @(posedge clk);
    for (int k = n - 1; k >= 0; k--) begin
      bad_if.mosi <= w[k];
      bad_if.sclk <= 1'h1;
      repeat (4) @(posedge clk);
      bad_if.sclk <= 1'h0;
      repeat (4) @(posedge clk);
      rx = {rx[30:0], bad_if.miso_oe ? bad_if.miso : 1'hz};
    end
    repeat (4) @(posedge clk);
    bad_if.cs_n <= 1'h1;
    bad_if.mosi <= ~bad_if.mosi;
    wait_for(2);
    repeat (8) @(posedge clk);
  endtask

  initial begin
    #400_000;
    miscompares++;
    stop_test();
  end

  initial begin
    sys_rst = 1'h1;
    {req, req_sel, req_idx, req_wr, req_addr, req_data} = '0;
    bad_if.sclk = 1'h0;
    bad_if.cs_n = 1'h1;
    bad_if.mosi = 1'h0;
    {miscompares, tests_run} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    xfer(3'h0, 3'h1, 1'h1, 16'h0000, 8'hC8);
    chk(wr_log, {3'h0, 3'h1, 16'h0000, 8'hC8});
    for (int s = 1; s < 8; s++) begin
      xfer(s[2:0], 3'h0, 1'h1, 16'h1765, 8'hD9);
      chk(wr_log, {s[2:0], 3'h0, (s == 1 || s == 2 || s == 7) ?
          16'h1765 : 16'h0065, 8'hD9});
      chk(last_status, 8'h02);
    end
    chk(wr_cnt, 8);
    xfer(3'h4, 3'h0, 1'h0, 16'h007F, 8'h00);
    xfer(3'h6, 3'h0, 1'h0, 16'h00C0, 8'h00);
    chk(rsp_data, 8'h25);
    xfer(3'h0, 3'h2, 1'h1, 16'h0000, 8'h11);
    chk(rsp_data, 8'h9A);
    xfer(3'h2, 3'h0, 1'h0, 16'h1234, 8'h00);
    chk(rsp_data, 8'h00);
    xfer(3'h7, 3'h0, 1'h0, 16'h0000, 8'h00);
    chk(rsp_data, 8'h6E);
    xfer(3'h1, 3'h1, 1'h1, 16'h1765, 8'hC8);
    chk(last_status, 8'hA2);
    chk(wr_cnt, 9);
    xfer(3'h0, 3'h0, 1'h0, 16'h0000, 8'h00);
    chk(last_status, 8'h02);
    chk(fd_cnt, 15);
    chk(rd_cnt, 5);
    send_raw(24, 32'h00137F34);
    chk(rx[23:16], 8'h02);
    chk(x_status, 8'h02);
    for (int k = 0; k < 4; k++) begin
      send_raw(n_tab[k], w_tab[k]);
      chk(x_status, e_tab[k]);
    end
    chk(x_wr_cnt, 1);
    stop_test();
  end
endmodule
`default_nettype wire
